// File: verilog/osd_port.sv
// Purpose: I/O port decode, channel select and acknowledge timing for an eight channel serial board
// Assumes: bus strobes and address are synchronous to aclk; registers reached over AXI4-Lite
// Notes: every output is registered, so bus side outputs lag the bus inputs by one cycle
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.

// Operation
// [RULE_01] answer 32 consecutive ports whose base is any multiple of 32
// [RULE_02] match only when every compared bit 15..5 equals its setting
// [RULE_03] closed setting compares for zero, open setting compares for one
// [RULE_04] extended mode compares bits 15..5, otherwise only bits 7..5
// [RULE_05] channel selects only while matched and a read or write strobe is active
// [RULE_06] bits 4..2 assert exactly one of eight channel selects
// [RULE_07] each channel holds four consecutive ports, all readable and writable
// [RULE_08] channel read/write line high for write, low for read
// [RULE_09] xack and aack each delayed 0 to 800 ns in 100 ns steps
// [RULE_10] xack should match access time, aack should come as early as possible
// [RULE_11] every command to this board is acknowledged
// [RULE_12] receiver full or transmitter empty from any channel can raise interrupt
// [RULE_13] data flows both into and out of the board
// [RULE_14] data drives bus only while addressed and reading, else inward
// [RULE_15] delay chain cleared while idle, shifts ones at command clock rate
// [RULE_16] ack drivers enabled only during a command; zero delay means at select
// [RULE_17] master ends the cycle on xack only, aack is advance notice
// [RULE_18] address bits 1..0 go to the channel as its register select
module osd_port #(
  parameter int CCLK_CYC = osd_pkg::CCLK_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // system bus command and address
  input wire logic [15:0] io_addr,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  // system bus data, two-way
  input wire logic [7:0] bus_data_in,
  output logic [7:0] bus_data_out,
  output logic bus_data_oe,
  // system bus acknowledges
  output logic xack,
  output logic aack,
  output logic ack_oe,
  // channel side
  output logic [7:0] chan_cs,
  output logic chan_rw,
  output logic [1:0] chan_reg_sel,
  output logic [7:0] chan_wdata,
  input wire logic [7:0] chan_rdata,
  input wire logic [7:0] chan_rx_full,
  input wire logic [7:0] chan_tx_empty,
  // interrupt
  output logic irq
);

  osd_pkg::osd_state_t s_q;
  osd_pkg::osd_state_t n;

  osd_ack_if ack_link ();

  // byte-lane merge of a register write
  function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] data,
                                           input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction : wr_merge

  // compare address bits against switch settings
  function automatic logic addr_match(input logic [15:0] addr, input logic [10:0] open_sw,
                                      input logic ext);
    logic [10:0] diff;
    logic [10:0] used;
    // closed (0) wants a low line, open (1) wants a high line
    diff = addr[15:osd_pkg::MATCH_LSB] ^ open_sw;
    // narrow mode drops bits 15..8 from the compare
    used = ext ? 11'h7ff : 11'h007;
    return ~|(diff & used);
  endfunction : addr_match

  // choose an acknowledge timing from the chain
  function automatic logic ack_pick(input logic [3:0] sel, input logic [7:0] taps);
    logic r;
    if (sel == 4'h0) begin
      r = 1'b1;
    end else if (sel > 4'h8) begin
      r = taps[7];
    end else begin
      r = taps[3'(sel - 4'h1)];
    end
    return r;
  endfunction : ack_pick

  // acknowledge delay chain
  osd_ack_chain u_chain (
    .aclk (aclk),
    .aresetn (aresetn),
    .ack (ack_link.chain)
  );

  // divider word type, declared ahead of its first use
  typedef logic [osd_pkg::DIV_W-1:0] osd_div_t;

  // chain control from the current state
  // [RULE_15] idle clear, timed shift
  assign ack_link.clear = !s_q.active;
  assign ack_link.tick = s_q.active && (s_q.div == osd_div_t'(CCLK_CYC - 1));

  // next state of everything
  always_comb begin
    logic cmd;
    logic sel;
    logic act;
    logic [15:0] ev;
    logic [15:0] clr;
    logic [31:0] base_word;
    logic [31:0] ack_word;
    logic [31:0] mask_word;
    logic [31:0] mw;
    cmd = 1'b0;
    sel = 1'b0;
    act = 1'b0;
    ev = '0;
    clr = '0;
    base_word = '0;
    ack_word = '0;
    mask_word = '0;
    mw = '0;
    n = s_q;

    // register views
    base_word[15:osd_pkg::MATCH_LSB] = s_q.open_sw;
    base_word[osd_pkg::BASE_EXT_BIT] = s_q.ext_io;
    ack_word[osd_pkg::ACK_XSEL_LSB +: osd_pkg::SEL_W] = s_q.xack_sel;
    ack_word[osd_pkg::ACK_ASEL_LSB +: osd_pkg::SEL_W] = s_q.aack_sel;
    mask_word[15:0] = s_q.mask;

    // axi write channel capture, either order
    if (s_axi_awvalid && s_q.awready) begin
      n.aw_held = 1'b1;
      n.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_q.wready) begin
      n.w_held = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // perform a write once address and data are both held
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = osd_pkg::RESP_OKAY;
      unique case (s_q.aw_addr)
        osd_pkg::REG_BASE: begin
          // [RULE_01] base on 32-port steps
          mw = wr_merge(base_word, s_q.w_data, s_q.w_strb);
          n.open_sw = mw[15:osd_pkg::MATCH_LSB];
          n.ext_io = mw[osd_pkg::BASE_EXT_BIT];
        end
        osd_pkg::REG_ACK: begin
          // [RULE_10] software picks both delays
          mw = wr_merge(ack_word, s_q.w_data, s_q.w_strb);
          n.xack_sel = mw[osd_pkg::ACK_XSEL_LSB +: osd_pkg::SEL_W];
          n.aack_sel = mw[osd_pkg::ACK_ASEL_LSB +: osd_pkg::SEL_W];
        end
        osd_pkg::REG_STATUS: begin
          mw = wr_merge(32'h0000_0000, s_q.w_data, s_q.w_strb);
          clr = mw[15:0];
        end
        osd_pkg::REG_MASK: begin
          mw = wr_merge(mask_word, s_q.w_data, s_q.w_strb);
          n.mask = mw[15:0];
        end
        osd_pkg::REG_STATE: begin
          n.bresp = osd_pkg::RESP_OKAY;
        end
        default: begin
          n.bresp = osd_pkg::RESP_SLVERR;
        end
      endcase
    end

    // axi read
    if (s_q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      n.rvalid = 1'b1;
      n.rresp = osd_pkg::RESP_OKAY;
      n.rdata = '0;
      unique case (s_axi_araddr[7:0])
        osd_pkg::REG_BASE: begin
          n.rdata = base_word;
        end
        osd_pkg::REG_ACK: begin
          n.rdata = ack_word;
        end
        osd_pkg::REG_STATUS: begin
          n.rdata[15:0] = s_q.status;
        end
        osd_pkg::REG_MASK: begin
          n.rdata = mask_word;
        end
        osd_pkg::REG_STATE: begin
          n.rdata[osd_pkg::STATE_TAPS_LSB +: osd_pkg::N_TAPS] = ack_link.taps;
          n.rdata[osd_pkg::STATE_ACTIVE_BIT] = s_q.active;
          n.rdata[osd_pkg::STATE_DOE_BIT] = s_q.doe;
          n.rdata[osd_pkg::STATE_CH_LSB +: 3] = s_q.last_ch;
        end
        default: begin
          n.rresp = osd_pkg::RESP_SLVERR;
        end
      endcase
    end

    // ready flags follow the next holding state
    n.awready = !n.aw_held && !n.bvalid;
    n.wready = !n.w_held && !n.bvalid;
    n.arready = !n.rvalid;

    // board match and command detect
    // [RULE_02] all compared bits equal
    // [RULE_03] closed zero, open one
    // [RULE_04] extended or narrow compare
    sel = addr_match(io_addr, s_q.open_sw, s_q.ext_io);
    cmd = !io_rd_n || !io_wr_n;
    // [RULE_05] decoder gated by command
    act = sel && cmd;
    n.active = act;

    // channel select and register select
    // [RULE_06] one of eight selects
    // [RULE_07] four ports per channel
    n.cs = act ? 8'(8'h01 << io_addr[4:osd_pkg::CHSEL_LSB]) : 8'h00;
    if (act) begin
      n.last_ch = io_addr[4:osd_pkg::CHSEL_LSB];
    end
    // [RULE_18] low bits pick channel port
    n.reg_sel = io_addr[1:0];
    // [RULE_08] write high, read low
    n.rw = !io_wr_n;

    // data path both ways
    // [RULE_13] inward and outward data
    n.wdata = bus_data_in;
    n.rdat = chan_rdata;
    // [RULE_14] drive only on addressed read
    n.doe = sel && !io_rd_n;

    // command clock divider, restarts with every command
    if (!s_q.active) begin
      n.div = '0;
    end else if (s_q.div == osd_div_t'(CCLK_CYC - 1)) begin
      n.div = '0;
    end else begin
      n.div = s_q.div + osd_div_t'(1);
    end

    // acknowledge outputs
    // [RULE_09] selectable delays
    // [RULE_11] every command acknowledged
    // [RULE_16] drivers enabled during command
    n.ack_oe = act;
    n.xack = act && s_q.active && ack_pick(s_q.xack_sel, ack_link.taps);
    n.aack = act && s_q.active && ack_pick(s_q.aack_sel, ack_link.taps);
    if (act && (s_q.xack_sel == 4'h0)) begin
      n.xack = 1'b1;
    end
    if (act && (s_q.aack_sel == 4'h0)) begin
      n.aack = 1'b1;
    end

    // sticky channel events, set wins over clear
    // [RULE_12] receiver full or transmitter empty
    ev = {chan_tx_empty, chan_rx_full};
    n.ev_prev = ev;
    n.status = (s_q.status & ~clr) | (ev & ~s_q.ev_prev);
    n.irq = |(n.status & n.mask);
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.open_sw <= osd_pkg::SW_RST;
      s_q.ext_io <= osd_pkg::EXT_RST;
      s_q.xack_sel <= osd_pkg::SEL_RST;
      s_q.aack_sel <= osd_pkg::SEL_RST;
      s_q.mask <= osd_pkg::MASK_RST;
    end else begin
      s_q <= n;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign bus_data_out = s_q.rdat;
  assign bus_data_oe = s_q.doe;
  assign xack = s_q.xack;
  assign aack = s_q.aack;
  assign ack_oe = s_q.ack_oe;
  assign chan_cs = s_q.cs;
  assign chan_rw = s_q.rw;
  assign chan_reg_sel = s_q.reg_sel;
  assign chan_wdata = s_q.wdata;
  assign irq = s_q.irq;

endmodule : osd_port

// File: verilog/osd_pkg.sv
// Purpose: shared constants and types of the octal serial port decode and acknowledge block
// Assumes: one 50 MHz clock, 32-bit AXI4-Lite register access
// Notes: all offsets, field positions, reset values and cycle counts live here
package osd_pkg;

  // clock and command clock timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int CCLK_PERIOD_NS = 100;
  localparam int CCLK_CYCLES = (CCLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W = 3;

  // port geometry
  localparam int N_CHAN = 8;
  localparam int N_TAPS = 8;
  localparam int IO_ADDR_W = 16;
  localparam int MATCH_LSB = 5;
  localparam int NARROW_MSB = 7;
  localparam int CHSEL_LSB = 2;
  localparam int SEL_W = 4;

  // register byte offsets
  localparam logic [7:0] REG_BASE = 8'h00;
  localparam logic [7:0] REG_ACK = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0c;
  localparam logic [7:0] REG_STATE = 8'h10;

  // field positions
  localparam int BASE_EXT_BIT = 0;
  localparam int ACK_XSEL_LSB = 0;
  localparam int ACK_ASEL_LSB = 8;
  localparam int STATUS_TX_LSB = 8;
  localparam int STATE_TAPS_LSB = 0;
  localparam int STATE_ACTIVE_BIT = 8;
  localparam int STATE_DOE_BIT = 9;
  localparam int STATE_CH_LSB = 12;

  // reset values
  localparam logic [10:0] SW_RST = 11'h000;
  localparam logic EXT_RST = 1'b0;
  localparam logic [3:0] SEL_RST = 4'h0;
  localparam logic [15:0] MASK_RST = 16'h0000;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // complete state of the top module
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [10:0] open_sw;
    logic ext_io;
    logic [3:0] xack_sel;
    logic [3:0] aack_sel;
    logic [15:0] status;
    logic [15:0] mask;
    logic [15:0] ev_prev;
    logic irq;
    logic [7:0] cs;
    logic rw;
    logic [1:0] reg_sel;
    logic [7:0] wdata;
    logic [7:0] rdat;
    logic doe;
    logic xack;
    logic aack;
    logic ack_oe;
    logic [DIV_W-1:0] div;
    logic active;
    logic [2:0] last_ch;
  } osd_state_t;

  // state of the delay chain
  typedef struct packed {
    logic [N_TAPS-1:0] taps;
  } osd_chain_t;

endpackage : osd_pkg

// File: verilog/osd_ack_if.sv
// Purpose: link between the port logic and its acknowledge delay chain
// Assumes: both ends on aclk
// Notes: clear holds the chain empty, tick shifts in a one
interface osd_ack_if;
  logic clear;
  logic tick;
  logic [osd_pkg::N_TAPS-1:0] taps;

  modport ctl (output clear, output tick, input taps);
  modport chain (input clear, input tick, output taps);
endinterface : osd_ack_if

// File: verilog/osd_ack_chain.sv
// Purpose: delay chain giving acknowledge taps at command clock steps
// Assumes: tick is a one-cycle enable at the command clock rate
// Notes: tap k rises k+1 ticks after clear is released
module osd_ack_chain (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link to port logic
  osd_ack_if.chain ack
);

  osd_pkg::osd_chain_t s_q;
  osd_pkg::osd_chain_t s_d;

  // hold cleared while idle, shift ones on each tick
  always_comb begin
    s_d = s_q;
    if (ack.clear) begin
      s_d.taps = '0;
    end else if (ack.tick) begin
      s_d.taps = {s_q.taps[osd_pkg::N_TAPS-2:0], 1'b1};
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ack.taps = s_q.taps;

endmodule : osd_ack_chain

// File: testbench/osd_port_asserts.sv
// Purpose: port checks for osd_port
// Assumes: one clock, synchronous active-low reset
// Notes: attached by the bind at the foot of this file
module osd_port_asserts (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // system bus
  input wire logic [15:0] io_addr,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  input wire logic [7:0] bus_data_in,
  input wire logic bus_data_oe,
  input wire logic xack,
  input wire logic aack,
  input wire logic ack_oe,
  // channel side
  input wire logic [7:0] chan_cs,
  input wire logic chan_rw,
  input wire logic [1:0] chan_reg_sel,
  input wire logic [7:0] chan_wdata
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic cmd;
  logic sel;
  logic [2:0] ch;
  // command present, channel field, any select up
  assign cmd = !io_rd_n || !io_wr_n;
  assign ch = io_addr[4:2];
  assign sel = chan_cs != 8'h00;

  a_cs_onehot: assert property ($onehot0(chan_cs))
    else $error("channel selects not one-hot");
  a_cs_cmd: assert property (sel |-> $past(cmd))
    else $error("select without command");
  a_cs_index: assert property (sel |-> chan_cs == 8'h01 << $past(ch))
    else $error("wrong channel selected");
  a_reg_sel: assert property (sel |-> chan_reg_sel == 2'($past(io_addr)))
    else $error("wrong register select");
  a_rw_level: assert property (sel |-> chan_rw == !$past(io_wr_n))
    else $error("wrong read/write level");
  a_wdata_in: assert property (sel && chan_rw |-> chan_wdata == $past(bus_data_in))
    else $error("write data not passed in");
  a_oe_read: assert property (bus_data_oe |-> !$past(io_rd_n))
    else $error("data driven outward without read");
  a_idle_quiet: assert property (!cmd |=> !ack_oe && !xack && !aack && !sel)
    else $error("outputs active while idle");
  a_ack_gated: assert property (xack || aack |-> ack_oe)
    else $error("acknowledge without driver enable");
  a_ack_bound: assert property ($rose(ack_oe) |-> ##[0:48] (xack || !ack_oe))
    else $error("command not acknowledged in time");

  // main scenarios
  c_read: cover property (bus_data_oe && xack);
  c_write: cover property (sel && chan_rw && xack);
  c_aack_first: cover property (aack && !xack);
endmodule : osd_port_asserts

bind osd_port osd_port_asserts osd_port_asserts_i (
  .aclk, .aresetn, .io_addr, .io_rd_n, .io_wr_n, .bus_data_in, .bus_data_oe,
  .xack, .aack, .ack_oe, .chan_cs, .chan_rw, .chan_reg_sel, .chan_wdata
);

// File: testbench/osd_bus_master.sv
// Purpose: processor model on the system bus side
// Assumes: strobes change by non-blocking assignment after a rising edge
// Notes: released address and data show the inverse of their last value, strobes go high
module osd_bus_master (
  // clock
  input wire logic aclk,
  // command, address and data out
  output logic [15:0] io_addr,
  output logic io_rd_n,
  output logic io_wr_n,
  output logic [7:0] bus_data_in,
  // answers from the board
  input wire logic [7:0] bus_data_out,
  input wire logic xack,
  input wire logic aack
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus from time zero
  initial begin
    io_addr = 16'h0000;
    io_rd_n = 1'b1;
    io_wr_n = 1'b1;
    bus_data_in = 8'h00;
  end
  // one command; nx and na count edges to xack and aack, 0 if none
  // end on xack only
  task automatic io_cycle(input logic [15:0] a, input logic wr, input logic [7:0] d,
                          output logic [7:0] rd, output int nx, output int na);
    nx = 0;
    na = 0;
    rd = 8'h00;
    @(posedge aclk);
    io_addr <= a;
    bus_data_in <= d;
    io_rd_n <= wr;
    io_wr_n <= !wr;
    for (int n = 1; n <= 60 && nx == 0; n++) begin
      @(posedge aclk);
      if (aack && na == 0) na = n;
      if (xack) nx = n;
      if (xack) rd = bus_data_out;
    end
    io_rd_n <= 1'b1;
    io_wr_n <= 1'b1;
    io_addr <= ~a;
    bus_data_in <= ~d;
  endtask : io_cycle
endmodule : osd_bus_master

// File: testbench/test_octal_serial_io_decode_ack.sv
// Purpose: self-checking bench for osd_port
// Assumes: axi4-lite master tasks, bus model osd_bus_master
// Notes: command clock shortened to CC cycles
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module test_octal_serial_io_decode_ack;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CC = 2;
  localparam logic [15:0] TA [6] = '{16'h1240, 16'h125f, 16'h0240, 16'h1340, 16'h1260, 16'h1200};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, io_rd_n, io_wr_n, bus_data_oe;
  logic xack, aack, ack_oe, chan_rw, irq, rw_seen, oe_seen;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, chan_reg_sel, rs_seen, r;
  logic [15:0] io_addr;
  logic [7:0] bus_data_in, bus_data_out, chan_cs, chan_wdata, chan_rdata, chan_rx_full, chan_tx_empty;
  logic [7:0] cs_seen, wd_seen, rd, any_cs;
  int mismatches, total_checks, nx, na;

  osd_port #(.CCLK_CYC(CC)) osd_port_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .io_addr, .io_rd_n, .io_wr_n, .bus_data_in, .bus_data_out, .bus_data_oe, .xack, .aack, .ack_oe,
    .chan_cs, .chan_rw, .chan_reg_sel, .chan_wdata, .chan_rdata, .chan_rx_full, .chan_tx_empty, .irq);
  osd_bus_master osd_bus_master_i (.aclk, .io_addr, .io_rd_n, .io_wr_n, .bus_data_in, .bus_data_out,
    .xack, .aack);

  // channel read data tells which channel answered
  assign chan_rdata = chan_cs ^ 8'h3c;
  // clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // snapshot of the channel side at the acknowledge edge
  always @(posedge aclk) begin
    if (xack) {cs_seen, rw_seen, rs_seen, wd_seen, oe_seen} <= {chan_cs, chan_rw, chan_reg_sel, chan_wdata, bus_data_oe};
    any_cs <= any_cs | chan_cs;
  end

  // verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // a spent wait bound ends the run
  task automatic bound(input int n);
    if (n >= 50) mismatches++;
    if (n >= 50) tally_and_finish();
  endtask : bound
  // axi4-lite write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= {24'h000000, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    bound(n);
  endtask : axi_wr
  // axi4-lite read
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= {24'h000000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    bound(n);
  endtask : axi_rd
  // one system bus command, results settled on return
  task automatic io(input logic [15:0] a, input logic wr, input logic [7:0] d);
    @(negedge aclk);
    any_cs = 8'h00;
    osd_bus_master_i.io_cycle(a, wr, d, rd, nx, na);
    @(negedge aclk);
  endtask : io
  // wait then look at the interrupt line
  task automatic irq_is(input logic e);
    repeat (3) @(negedge aclk);
    `CHK("irq", e, irq)
  endtask : irq_is

  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    {chan_rx_full, chan_tx_empty, any_cs} = '0;
    mismatches = 0;
    total_checks = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      axi_rd(8'(4 * i), v, r);
      `CHK("reset value", 32'h0, v)
    end
    axi_rd(8'h20, v, r);
    `CHK("rresp", osd_pkg::RESP_SLVERR, r)
    axi_wr(8'h24, 32'hffffffff, r);
    `CHK("bresp", osd_pkg::RESP_SLVERR, r)
    axi_wr(osd_pkg::REG_BASE, 32'h0000ffa0, r);
    axi_rd(osd_pkg::REG_BASE, v, r);
    `CHK("base", 32'h0000ffa0, v)
    // read data trail the select by one cycle, so xack waits one step
    axi_wr(osd_pkg::REG_ACK, 32'h00000001, r);
    `CHK("bresp ok", osd_pkg::RESP_OKAY, r)
    for (int i = 0; i < 16; i++) begin
      io({8'h12, 3'h5, 3'(i), 2'(i)}, i / 8, 8'(i * 17));
      `CHK("ack", 1'b1, nx != 0)
      `CHK("cs", 8'h01 << (i % 8), cs_seen)
      `CHK("reg", 2'(i), rs_seen)
      `CHK("rw", 1'(i / 8), rw_seen)
      `CHK("oe", 1'(i < 8), oe_seen)
      `CHK("data", i / 8 ? 8'(i * 17) : (8'h01 << (i % 8)) ^ 8'h3c, i / 8 ? wd_seen : rd)
    end
    io(16'h12e0, 1'b0, 8'h00);
    `CHK("narrow miss", 8'h00, any_cs)
    axi_wr(osd_pkg::REG_BASE, 32'h00001241, r);
    for (int i = 0; i < 6; i++) begin
      io(TA[i], 1'b0, 8'h00);
      `CHK("hit", 1'(i < 2), nx != 0)
      `CHK("cs hit", 1'(i < 2), any_cs != 8'h00)
    end
    // aack never later than xack
    for (int k = 0; k < 10; k++) begin
      axi_wr(osd_pkg::REG_ACK, (32'(k) << osd_pkg::ACK_XSEL_LSB) | (32'(k / 2) << osd_pkg::ACK_ASEL_LSB), r);
      io(16'h1248, 1'b0, 8'h00);
      `CHK("xack delay", k == 0 ? 2 : CC * (k > 8 ? 8 : k) + 3, nx)
      `CHK("aack delay", k / 2 == 0 ? 2 : CC * (k / 2) + 3, na)
    end
    axi_wr(osd_pkg::REG_MASK, 32'h00000001, r);
    chan_rx_full <= 8'h01;
    chan_tx_empty <= 8'h08;
    irq_is(1'b1);
    axi_rd(osd_pkg::REG_STATUS, v, r);
    `CHK("status", 32'h00000801, v)
    axi_wr(osd_pkg::REG_STATUS, 32'h00000001, r);
    irq_is(1'b0);
    axi_wr(osd_pkg::REG_MASK, 32'h00000800, r);
    irq_is(1'b1);
    axi_wr(osd_pkg::REG_STATUS, 32'h0000ffff, r);
    irq_is(1'b0);
    // state view: chain empty, idle, last channel 2; writes there are ignored
    axi_wr(osd_pkg::REG_STATE, 32'hffffffff, r);
    `CHK("state bresp", osd_pkg::RESP_OKAY, r)
    axi_rd(osd_pkg::REG_STATE, v, r);
    `CHK("state", 32'h00002000, v)
    tally_and_finish();
  end
endmodule : test_octal_serial_io_decode_ack
